// File: core/ccm_ctrl_pkg.sv
package ccm_ctrl_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_KS_EVENT = 12'h100;
    localparam logic [11:0] OFS_CD_EVENT = 12'h104;
    localparam logic [11:0] OFS_ERR_EVENT = 12'h108;
    localparam logic [11:0] OFS_SHORTCUTS = 12'h200;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_MIC = 12'h400;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_MODE = 12'h504;
    // Field positions
    localparam int BIT_KS = 0;
    localparam int BIT_CD = 1;
    localparam int BIT_ERR = 2;
    localparam int BIT_SHORT = 0;
    localparam int BIT_MIC = 0;
    localparam int BIT_EVENT = 0;
    // Field widths
    localparam int ENABLE_W = 2;
    localparam int MODE_W = 5;
    localparam int NUM_IRQ = 3;
    // Enable field encodings
    localparam logic [1:0] ENABLE_OFF = 2'h0;
    localparam logic [1:0] ENABLE_ON = 2'h2;
    // Reset values
    localparam logic [2:0] IRQ_EN_RESET = 3'h0;
    localparam logic [1:0] ENABLE_RESET = 2'h0;
    localparam logic [4:0] MODE_RESET = 5'h01;
    localparam logic [31:0] READ_ZERO = 32'h0;
    // Tracker states for the key-stream to cipher chain
    typedef enum logic [2:0] {
        CH_IDLE = 3'b001,
        CH_WAIT = 3'b010,
        CH_FIRE = 3'b100
    } chain_state_t;
endpackage : ccm_ctrl_pkg

// File: core/event_flag.sv
`timescale 1ns/1ps
// Sticky event flag: hardware set wins over software write of 0
module event_flag (
    input wire logic mclk, // Clock
    input wire logic rst, // Async reset
    input wire logic hwSet, // Event pulse
    input wire logic swWrite, // Software write strobe
    input wire logic swData, // Software write value
    output logic flag // Sticky flag
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (hwSet) begin
            flag <= 1'b1;
        end else if (swWrite) begin
            flag <= swData;
        end
    end
endmodule : event_flag

// File: core/ccm_cipher_ctrl_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Shortcut bit set: key-stream-done triggers cipher run task automatically.
// - Irq set bit A write 1 enables key-stream-done interrupt; reads state.
// - Irq set bit B write 1 enables cipher-done interrupt; reads state.
// - Irq set bit C write 1 enables deprecated error interrupt.
// - Irq clear bit A write 1 disables key-stream-done interrupt.
// - Irq clear bit B write 1 disables cipher-done interrupt.
// - Irq clear bit C write 1 disables error interrupt.
// - Read-only bit shows last decryption integrity result, 1 passed.
// - Two-bit enable field: 0 disables engine, 2 enables it.
// - Key-stream-done flag set on completion; software may write it.
// - Cipher-done flag set when encrypt or decrypt finishes.
// - Mode settings sampled whenever key-stream start or cipher run fires.
module ccm_cipher_ctrl_regs
    import ccm_ctrl_pkg::*;
(
    input wire logic mclk, // 100 MHz clock
    input wire logic rst, // Async reset, high
    input wire logic [11:0] addr, // Byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after rd
    input wire logic keystreamDone, // Key-stream generation finished
    input wire logic cipherDone, // Cipher operation finished
    input wire logic cipherError, // Error pulse, deprecated
    input wire logic micPass, // Integrity result of datapath
    input wire logic micValid, // Pulse: micPass is fresh
    input wire logic keystreamStart, // Key-stream start task pulse
    input wire logic cipherRunSw, // Cipher run task from software
    output logic cipherRunTask, // Cipher run task to datapath
    output logic engineEnabled, // Engine enabled level
    output logic [4:0] activeMode, // Mode captured at task
    output logic irq // Level interrupt
);
    ////////////////////////////////////////////////////////////////////
    logic shortcut;
    logic [2:0] irqEn;
    logic [1:0] enableField;
    logic [4:0] modeReg;
    logic micResult;
    logic [2:0] flags;
    logic [2:0] hwEvents;
    logic [2:0] flagWr;
    logic chainFire;
    chain_state_t chainState;

    // One address decode shared by read and write paths
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        return a == ofs;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////
    // shortcut register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shortcut <= 1'b0;
        end else if (wr && hit(addr, OFS_SHORTCUTS)) begin
            shortcut <= wdata[BIT_SHORT];
        end
    end

    // enable set and clear, zeros ignored
    // bits A, B and C share this path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irqEn <= IRQ_EN_RESET;
        end else if (wr && hit(addr, OFS_IRQ_SET)) begin
            irqEn <= irqEn | wdata[NUM_IRQ-1:0];
        end else if (wr && hit(addr, OFS_IRQ_CLR)) begin
            irqEn <= irqEn & ~wdata[NUM_IRQ-1:0];
        end
    end

    // enable field; only the value 2 turns the engine on
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enableField <= ENABLE_RESET;
        end else if (wr && hit(addr, OFS_ENABLE)) begin
            enableField <= wdata[ENABLE_W-1:0];
        end
    end

    // engine level kept in a flop beside the field
    // Reserved codes 1 and 3 leave the engine off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            engineEnabled <= (ENABLE_RESET == ENABLE_ON);
        end else if (wr && hit(addr, OFS_ENABLE)) begin
            engineEnabled <= (wdata[ENABLE_W-1:0] == ENABLE_ON);
        end
    end

    // Mode register held for the datapath
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            modeReg <= MODE_RESET;
        end else if (wr && hit(addr, OFS_MODE)) begin
            modeReg <= wdata[MODE_W-1:0];
        end
    end

    // mode latched when either task fires
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            activeMode <= MODE_RESET;
        end else if (keystreamStart || cipherRunTask) begin
            activeMode <= modeReg;
        end
    end

    // integrity result, updated only by the datapath
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            micResult <= 1'b0;
        end else if (micValid) begin
            micResult <= micPass;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky event flags, hardware set beats clear
    assign hwEvents = {cipherError, cipherDone, keystreamDone};
    assign flagWr = {wr && hit(addr, OFS_ERR_EVENT),
                     wr && hit(addr, OFS_CD_EVENT),
                     wr && hit(addr, OFS_KS_EVENT)};
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_flag
        event_flag u_flag (
            .mclk(mclk),
            .rst(rst),
            .hwSet(hwEvents[i]),
            .swWrite(flagWr[i]),
            .swData(wdata[BIT_EVENT]),
            .flag(flags[i])
        );
    end

    ////////////////////////////////////////////////////////////////////
    // chain tracker: fire one cycle after the event
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            chainState <= CH_IDLE;
        end else begin
            unique case (chainState)
                CH_IDLE: begin
                    if (keystreamDone && shortcut) begin
                        chainState <= CH_FIRE;
                    end
                end
                CH_FIRE: begin
                    chainState <= (keystreamDone && shortcut) ?
                                  CH_FIRE : CH_IDLE;
                end
                CH_WAIT: begin
                    chainState <= CH_IDLE;
                end
                default: begin
                    chainState <= CH_IDLE;
                end
            endcase
        end
    end
    assign chainFire = (chainState == CH_FIRE);
    // Cipher task from software or from the shortcut
    assign cipherRunTask = cipherRunSw || chainFire;

    assign irq = |(flags & irqEn);

    ////////////////////////////////////////////////////////////////////
    // Read path; unmapped offsets read zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= READ_ZERO;
        end else if (rd) begin
            rdata <= READ_ZERO;
            if (hit(addr, OFS_KS_EVENT)) begin
                rdata[BIT_EVENT] <= flags[BIT_KS];
            end else if (hit(addr, OFS_CD_EVENT)) begin
                rdata[BIT_EVENT] <= flags[BIT_CD];
            end else if (hit(addr, OFS_ERR_EVENT)) begin
                rdata[BIT_EVENT] <= flags[BIT_ERR];
            end else if (hit(addr, OFS_SHORTCUTS)) begin
                rdata[BIT_SHORT] <= shortcut;
            end else if (hit(addr, OFS_IRQ_SET) ||
                         hit(addr, OFS_IRQ_CLR)) begin
                rdata[NUM_IRQ-1:0] <= irqEn;
            end else if (hit(addr, OFS_MIC)) begin
                rdata[BIT_MIC] <= micResult;
            end else if (hit(addr, OFS_ENABLE)) begin
                rdata[ENABLE_W-1:0] <= enableField;
            end else if (hit(addr, OFS_MODE)) begin
                rdata[MODE_W-1:0] <= modeReg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shortcut chains task
    a_short_chain_fires: assert property (
        @(posedge mclk) disable iff (rst)
        keystreamDone && shortcut |=> cipherRunTask)
        else $error("shortcut did not fire cipher task");

    a_chain_one_shot: assert property (
        @(posedge mclk) disable iff (rst)
        chainFire && !keystreamDone |=> !chainFire)
        else $error("chained task longer than one cycle");

    a_no_chain_off: assert property (
        @(posedge mclk) disable iff (rst)
        !shortcut && !cipherRunSw && !$past(shortcut) |-> !cipherRunTask)
        else $error("cipher task fired with shortcut off");

    a_irq_set_works: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_SET && wdata[BIT_KS] |=> irqEn[BIT_KS])
        else $error("set did not enable");

    a_irq_set_b: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_SET && wdata[BIT_CD] |=> irqEn[BIT_CD])
        else $error("set did not enable cipher-done");

    a_irq_set_c: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_SET && wdata[BIT_ERR] |=> irqEn[BIT_ERR])
        else $error("set did not enable error");

    a_irq_clr_a: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_CLR && wdata[BIT_KS] |=> !irqEn[BIT_KS])
        else $error("clear did not disable key-stream");

    a_irq_clr_works: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_CLR && wdata[BIT_CD] |=> !irqEn[BIT_CD])
        else $error("clear did not disable");

    a_irq_clr_c: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_CLR && wdata[BIT_ERR] |=> !irqEn[BIT_ERR])
        else $error("clear did not disable error");

    a_zero_keeps_en: assert property (
        @(posedge mclk) disable iff (rst)
        wr && (addr == OFS_IRQ_SET || addr == OFS_IRQ_CLR) &&
        wdata[NUM_IRQ-1:0] == '0 |=> $stable(irqEn))
        else $error("zero write changed enables");

    a_irq_level_ok: assert property (
        @(posedge mclk) disable iff (rst)
        $past(cipherDone) && irqEn[BIT_CD] |-> irq)
        else $error("interrupt missing");

    a_irq_drops: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_IRQ_CLR && wdata[NUM_IRQ-1:0] == irqEn |=> !irq)
        else $error("interrupt stayed with all enables cleared");

    a_event_sticky: assert property (
        @(posedge mclk) disable iff (rst)
        cipherDone |=> flags[BIT_CD])
        else $error("event flag not set");

    a_flag_sw_write: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_KS_EVENT && !keystreamDone
        |=> flags[BIT_KS] == $past(wdata[BIT_EVENT]))
        else $error("event flag ignored software write");

    a_enable_field: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_ENABLE && wdata[ENABLE_W-1:0] == ENABLE_ON
        |=> engineEnabled)
        else $error("engine not enabled");

    a_engine_off: assert property (
        @(posedge mclk) disable iff (rst)
        wr && addr == OFS_ENABLE && wdata[ENABLE_W-1:0] == ENABLE_OFF
        |=> !engineEnabled)
        else $error("engine not disabled");

    a_mic_readback: assert property (
        @(posedge mclk) disable iff (rst)
        micValid ##1 !micValid ##1 rd && addr == OFS_MIC && !micValid
        |=> rdata[BIT_MIC] == $past(micPass, 3))
        else $error("integrity result wrong");

    a_mode_capture: assert property (
        @(posedge mclk) disable iff (rst)
        keystreamStart |=> activeMode == $past(modeReg))
        else $error("mode not captured");

    a_mode_capture_run: assert property (
        @(posedge mclk) disable iff (rst)
        cipherRunTask |=> activeMode == $past(modeReg))
        else $error("mode not captured at run task");

    // Main scenarios reached
    c_chain: cover property (@(posedge mclk) keystreamDone && shortcut);
    c_chain_fire: cover property (@(posedge mclk) chainFire);
    c_irq: cover property (@(posedge mclk) $rose(irq));
    c_mic: cover property (@(posedge mclk) micValid && micPass);
    c_engine_on: cover property (@(posedge mclk) $rose(engineEnabled));
endmodule : ccm_cipher_ctrl_regs

// File: test/ccm_cipher_ctrl_regs_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        nChecks++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end
module ccm_cipher_ctrl_regs_test import ccm_ctrl_pkg::*;;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic keystreamDone = 1'b0;
    logic cipherDone = 1'b0;
    logic cipherError = 1'b0;
    logic micPass = 1'b0;
    logic micValid = 1'b0;
    logic keystreamStart = 1'b0;
    logic cipherRunSw = 1'b0;
    logic cipherRunTask;
    logic engineEnabled;
    logic [4:0] activeMode;
    logic irq;
    int miscompares = 0;
    int nChecks = 0;
    int cycles = 0;
    // Reset image: all zero except mode; last entry is an unmapped hole
    localparam logic [11:0] RST_A [7] = '{OFS_SHORTCUTS, OFS_IRQ_SET,
        OFS_IRQ_CLR, OFS_MIC, OFS_ENABLE, OFS_MODE, 12'h7fc};
    localparam logic [31:0] RST_V [7] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h1, 32'h0};

    ccm_cipher_ctrl_regs dut (.mclk(mclk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .keystreamDone(keystreamDone), .cipherDone(cipherDone),
        .cipherError(cipherError), .micPass(micPass), .micValid(micValid),
        .keystreamStart(keystreamStart), .cipherRunSw(cipherRunSw),
        .cipherRunTask(cipherRunTask), .engineEnabled(engineEnabled),
        .activeMode(activeMode), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 mclk = ~mclk;

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            endOfTest();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic endOfTest;
        if (miscompares == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : endOfTest

    // One-cycle write; strobe drops at the taking edge, so no reentry clash
    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask : wrReg

    // Read data is looked at only in the cycle after the strobe
    task automatic rdReg(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask : rdReg

    // Single-cycle event pulse; returns just after the sampling edge
    task automatic pulse(input int i);
        @(posedge mclk);
        case (i)
            0: keystreamDone <= 1'b1;
            1: cipherDone <= 1'b1;
            default: cipherError <= 1'b1;
        endcase
        @(posedge mclk);
        keystreamDone <= 1'b0;
        cipherDone <= 1'b0;
        cipherError <= 1'b0;
        #1;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 7; k++)
            rdReg(RST_A[k], RST_V[k]);
        // Unmapped and read-only places ignore writes
        wrReg(12'h7fc, 32'hffffffff);
        wrReg(OFS_MIC, 32'hffffffff);
        rdReg(12'h7fc, 32'h0);
        rdReg(OFS_MIC, 32'h0);
        // Per event: pending flag, enable set/clear, mask and flag clear
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            `CHK("irq", 1'b0, irq)
            wrReg(OFS_IRQ_SET, 32'h1 << i);
            `CHK("irq", 1'b1, irq)
            rdReg(OFS_IRQ_SET, 32'h1 << i);
            rdReg(OFS_IRQ_CLR, 32'h1 << i);
            rdReg(12'h100 + 12'(4 * i), 32'h1);
            wrReg(OFS_IRQ_SET, 32'h0);
            wrReg(OFS_IRQ_CLR, 32'h0);
            rdReg(OFS_IRQ_SET, 32'h1 << i);
            wrReg(OFS_IRQ_CLR, 32'h1 << i);
            `CHK("irq", 1'b0, irq)
            rdReg(OFS_IRQ_CLR, 32'h0);
            wrReg(OFS_IRQ_SET, 32'h1 << i);
            wrReg(12'h100 + 12'(4 * i), 32'h0);
            `CHK("irq", 1'b0, irq)
            rdReg(12'h100 + 12'(4 * i), 32'h0);
            // Event arriving while already enabled raises the line
            pulse(i);
            `CHK("irq", 1'b1, irq)
            wrReg(OFS_IRQ_CLR, 32'h1 << i);
        end
        // Shortcut off: no chaining; mode change waits for a task
        wrReg(OFS_MODE, 32'h0);
        pulse(0);
        `CHK("cipherRunTask", 1'b0, cipherRunTask)
        @(posedge mclk);
        #1;
        `CHK("activeMode", 5'h01, activeMode)
        wrReg(OFS_SHORTCUTS, 32'h1);
        rdReg(OFS_SHORTCUTS, 32'h1);
        pulse(0);
        `CHK("cipherRunTask", 1'b1, cipherRunTask)
        @(posedge mclk);
        #1;
        `CHK("cipherRunTask", 1'b0, cipherRunTask)
        `CHK("activeMode", 5'h00, activeMode)
        // Mode captured by the start task and by the software run task
        wrReg(OFS_MODE, 32'h3);
        @(posedge mclk);
        keystreamStart <= 1'b1;
        @(posedge mclk);
        keystreamStart <= 1'b0;
        #1;
        `CHK("activeMode", 5'h03, activeMode)
        wrReg(OFS_MODE, 32'h2);
        @(posedge mclk);
        cipherRunSw <= 1'b1;
        #1;
        `CHK("cipherRunTask", 1'b1, cipherRunTask)
        @(posedge mclk);
        cipherRunSw <= 1'b0;
        #1;
        `CHK("activeMode", 5'h02, activeMode)
        // Integrity result follows the latest fresh value
        for (int p = 1; p >= 0; p--) begin
            @(posedge mclk);
            micPass <= p[0];
            micValid <= 1'b1;
            @(posedge mclk);
            micValid <= 1'b0;
            rdReg(OFS_MIC, 32'(p));
        end
        // Only the value 2 turns the engine on
        wrReg(OFS_ENABLE, 32'h2);
        `CHK("engineEnabled", 1'b1, engineEnabled)
        rdReg(OFS_ENABLE, 32'h2);
        wrReg(OFS_ENABLE, 32'h1);
        `CHK("engineEnabled", 1'b0, engineEnabled)
        wrReg(OFS_ENABLE, 32'h2);
        wrReg(OFS_ENABLE, 32'h0);
        `CHK("engineEnabled", 1'b0, engineEnabled)
        endOfTest();
    end
endmodule : ccm_cipher_ctrl_regs_test
